// ===== logic/lrci_defines.vh
// Constants for the loop remote command interface
`ifndef LRCI_DEFINES_VH
`define LRCI_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LRCI_A_CTRL 8'h00
`define LRCI_A_STAT 8'h04
`define LRCI_A_RXC 8'h08
`define LRCI_A_TXD 8'h0C
`define LRCI_A_ACC 8'h10
`define LRCI_A_SET0 8'h14
`define LRCI_A_SETN 8'h2C
`define LRCI_A_DISP 8'h40
`define LRCI_A_DISPN 8'h7C
`define LRCI_NSET 7
`define LRCI_DLAST 4'hF
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LRCI_F_TONLY 0
`define LRCI_F_EVT 5
`define LRCI_F_SRQ 6
`define LRCI_PP_SENSE 3
`define LRCI_PP_BIT 2:0
`define LRCI_AF 4:0
`define LRCI_HF 7:5
`define LRCI_PF 7:4
`define LRCI_SF 4:2
`define LRCI_DF 5:2
`define LRCI_DIGF 1:0
// ----------------------------------------
// Status byte codes
// ----------------------------------------
`define LRCI_ST_OK 8'h80
`define LRCI_ST_RDY 8'hA2
`define LRCI_ST_RDYSRQ 8'hE2
// ----------------------------------------
// Loop frame kinds and messages
// ----------------------------------------
`define LRCI_K_DATA 2'h0
`define LRCI_K_CMD 2'h1
`define LRCI_K_RDY 2'h2
`define LRCI_K_IDY 2'h3
`define LRCI_C_IFC 8'h90
`define LRCI_C_DCL 8'h14
`define LRCI_C_SDC 8'h04
`define LRCI_C_PPC 8'h05
`define LRCI_C_PPU 8'h15
`define LRCI_C_PPD 8'h70
`define LRCI_C_UNL 8'h3F
`define LRCI_H_PPE 4'h8
`define LRCI_H_LAD 3'h1
`define LRCI_H_TAD 3'h2
`define LRCI_H_AAD 3'h4
`define LRCI_R_SST 8'h61
`define LRCI_ADDR_DEF 5'h01
// ----------------------------------------
// Characters and output modes
// ----------------------------------------
`define LRCI_CH_LF 8'h0A
`define LRCI_CH_O 8'h4F
`define LRCI_CH_U 8'h55
`define LRCI_CH_0 8'h30
`define LRCI_CH_SEMI 8'h3B
`define LRCI_CH_DMASK 8'hFC
`define LRCI_OU_MASK 2'h0
`define LRCI_OU_REQ 2'h1
`define LRCI_OU_HOLD 2'h2
`define LRCI_OU_EARLY 2'h3
// ----------------------------------------
// Instrument defaults after device clear
// ----------------------------------------
`define LRCI_D_FREQ 32'h0000_03EC
`define LRCI_D_SWEEP 32'h0F40_00CC
`define LRCI_D_SWCTL 32'h0003_0064
`define LRCI_D_TRANS 32'h0444_0F08
`define LRCI_D_TRANS2 32'h0258_0A14
`define LRCI_D_MISC 32'h0783_0258
`define LRCI_D_CHK 32'h0047_0000
`define LRCI_OKAY 2'h0
`define LRCI_SLVERR 2'h2
`endif

// ===== logic/lrci_top.v
// Loop remote command interface: loop message handling and register slave
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
// Operation
// RULE1 - Masked mode posts data-available, no request
// RULE2 - Request mode raises request with data-available
// RULE3 - Hold-off mode withholds handshake after line feed
// RULE4 - Early mode releases handshake on arrival
// RULE5 - Line feed ends every mnemonic command
// RULE6 - Interface clear unaddresses, keeps queued data
// RULE7 - Controller sends interface clear after timeout
// RULE8 - Device clear restores instrument default settings
// RULE9 - Device clear stops sweep, restores sweep defaults
// RULE10 - Device clear stops transients, restores defaults
// RULE11 - Device clear restores jitter band defaults
// RULE12 - Device clear restores return loss defaults
// RULE13 - Device clear restores self check defaults
// RULE14 - Address defaults one, else loop position
// RULE15 - Only one talker active at once
// RULE16 - No controller, trigger, power-down, dependent commands
// RULE17 - Serial poll returns present status byte
// RULE18 - Parallel poll answers only once configured
// RULE19 - Talk-only output key prints display image
// RULE20 - Commands forwarded inward, results sent outward
// RULE21 - Status codes carry bit seven set
// RULE22 - Event codes clear on poll, states persist
// RULE23 - Output mode persists, hold-off after power-up
`include "lrci_defines.vh"
module lrci_top (
    input wire mclk,
    input wire rstn,
    input wire ce,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire lp_rx_valid,
    input wire [1:0] lp_rx_kind,
    input wire [7:0] lp_rx_byte,
    output reg lp_rx_ack,
    output reg lp_tx_valid,
    output reg [1:0] lp_tx_kind,
    output reg [7:0] lp_tx_byte,
    input wire lp_tx_ready,
    output reg lp_srq,
    input wire out_key_n
);
// ----------------------------------------
// Parser states
// ----------------------------------------
localparam P_IDLE = 2'b00;
localparam P_O = 2'b01;
localparam P_U = 2'b10;
localparam P_DIG = 2'b11;
// ----------------------------------------
// State
// ----------------------------------------
reg [31:0] set_r [0:`LRCI_NSET-1];
reg [7:0] disp_r [0:15];
reg talk_r, lstn_r, srqen_r, early_r, hold_r, acc_r;
reg [4:0] addr_r;
reg [7:0] rxb_r, txd_r, evt_r, ppbyte_r;
reg rxv_r, txp_r, ppc_r, ppcfg_r, ppsense_r, ppreq_r, spoll_r;
reg [2:0] ppbit_r;
reg tonly_r, prn_r;
reg [3:0] pidx_r;
reg ks1_r, ks2_r, ks3_r;
reg [1:0] ou_st_r, ou_dig_r;
reg awv_r, wv_r;
reg [7:0] wa_r;
reg [31:0] wd_r;
reg [3:0] ws_r;
reg [31:0] rd_d;
reg rd_e;
integer i;
// ----------------------------------------
// Functions
// ----------------------------------------
function [31:0] f_def;
    input [2:0] idx;
    begin
        case (idx)
            3'h0: f_def = `LRCI_D_FREQ;
            3'h1: f_def = `LRCI_D_SWEEP;
            3'h2: f_def = `LRCI_D_SWCTL;
            3'h3: f_def = `LRCI_D_TRANS;
            3'h4: f_def = `LRCI_D_TRANS2;
            3'h5: f_def = `LRCI_D_MISC;
            3'h6: f_def = `LRCI_D_CHK;
            default: f_def = 32'h0000_0000;
        endcase
    end
endfunction
function f_inset;
    input [7:0] a;
    begin
        f_inset = (a >= `LRCI_A_SET0) && (a <= `LRCI_A_SETN) && (a[1:0] == 2'h0);
    end
endfunction
function f_indisp;
    input [7:0] a;
    begin
        f_indisp = (a >= `LRCI_A_DISP) && (a <= `LRCI_A_DISPN) && (a[1:0] == 2'h0);
    end
endfunction
function [2:0] f_sidx;
    input [7:0] a;
    reg [7:0] t;
    begin
        t = a - `LRCI_A_SET0;
        f_sidx = t[`LRCI_SF];
    end
endfunction
function [31:0] f_merge;
    input [31:0] o;
    input [31:0] n;
    input [3:0] s;
    begin
        f_merge = {s[3] ? n[31:24] : o[31:24], s[2] ? n[23:16] : o[23:16],
                   s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
    end
endfunction
// ----------------------------------------
// Decode
// ----------------------------------------
wire [7:0] b = lp_rx_byte;
wire is_data = (lp_rx_kind == `LRCI_K_DATA);
wire is_cmd = (lp_rx_kind == `LRCI_K_CMD);
wire is_idy = (lp_rx_kind == `LRCI_K_IDY);
wire tx_free = ~lp_tx_valid | lp_tx_ready;
wire rel_w = hold_r & acc_r & ~rxv_r;
wire take_w = lp_rx_valid & ~lp_rx_ack & ~hold_r & ~(is_data & lstn_r & rxv_r)
              & ~(is_idy & ppreq_r);
wire dclr_w = take_w & is_cmd & ((b == `LRCI_C_DCL) | ((b == `LRCI_C_SDC) & lstn_r));
wire need_w = (srqen_r & txp_r) | evt_r[`LRCI_F_SRQ];
wire key_w = ~ks2_r & ks3_r;
wire wr_go = awv_r & wv_r & ~s_axi_bvalid;
wire [7:0] stat_w = (evt_r != 8'h00) ? evt_r :
                    ~txp_r ? `LRCI_ST_OK :
                    srqen_r ? `LRCI_ST_RDYSRQ : `LRCI_ST_RDY; // RULE21
// ----------------------------------------
// Register read mux
// ----------------------------------------
always @* begin
    rd_d = 32'h0000_0000;
    rd_e = 1'b0;
    if (s_axi_araddr == `LRCI_A_CTRL) begin
        rd_d = {31'h0000_0000, tonly_r};
    end else if (s_axi_araddr == `LRCI_A_STAT) begin
        rd_d = {12'h000, addr_r, ppcfg_r, hold_r, rxv_r, lstn_r, talk_r, early_r,
                srqen_r, stat_w};
    end else if (s_axi_araddr == `LRCI_A_RXC) begin
        rd_d = {23'h00_0000, rxv_r, rxb_r};
    end else if (s_axi_araddr == `LRCI_A_TXD) begin
        rd_d = {23'h00_0000, txp_r, txd_r};
    end else if (s_axi_araddr == `LRCI_A_ACC) begin
        rd_d = {31'h0000_0000, acc_r};
    end else if (f_inset(s_axi_araddr)) begin
        rd_d = set_r[f_sidx(s_axi_araddr)];
    end else if (f_indisp(s_axi_araddr)) begin
        rd_d = {24'h00_0000, disp_r[s_axi_araddr[`LRCI_DF]]};
    end else begin
        rd_e = 1'b1;
    end
end
// ----------------------------------------
// Main sequential logic
// ----------------------------------------
always @(posedge mclk) begin
    if (!rstn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `LRCI_OKAY;
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `LRCI_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        awv_r <= 1'b0;
        wv_r <= 1'b0;
        wa_r <= 8'h00;
        wd_r <= 32'h0000_0000;
        ws_r <= 4'h0;
        lp_rx_ack <= 1'b0;
        lp_tx_valid <= 1'b0;
        lp_tx_kind <= `LRCI_K_DATA;
        lp_tx_byte <= 8'h00;
        lp_srq <= 1'b0;
        talk_r <= 1'b0;
        lstn_r <= 1'b0;
        addr_r <= `LRCI_ADDR_DEF; // RULE14
        srqen_r <= 1'b0;
        early_r <= 1'b0; // RULE23
        hold_r <= 1'b0;
        acc_r <= 1'b0;
        rxb_r <= 8'h00;
        rxv_r <= 1'b0;
        txd_r <= 8'h00;
        txp_r <= 1'b0;
        evt_r <= 8'h00;
        ppc_r <= 1'b0;
        ppcfg_r <= 1'b0;
        ppsense_r <= 1'b0;
        ppbit_r <= 3'h0;
        ppreq_r <= 1'b0;
        ppbyte_r <= 8'h00;
        spoll_r <= 1'b0;
        tonly_r <= 1'b0;
        prn_r <= 1'b0;
        pidx_r <= 4'h0;
        ks1_r <= 1'b1;
        ks2_r <= 1'b1;
        ks3_r <= 1'b1;
        ou_st_r <= P_IDLE;
        ou_dig_r <= 2'h0;
        for (i = 0; i < `LRCI_NSET; i = i + 1) begin
            set_r[i] <= f_def(i[2:0]);
        end
    end else if (ce) begin
        ks1_r <= out_key_n;
        ks2_r <= ks1_r;
        ks3_r <= ks2_r;
        lp_rx_ack <= 1'b0;
        lp_srq <= need_w; // RULE1 RULE2
        if (lp_tx_ready) begin
            lp_tx_valid <= 1'b0;
        end
        // Register read channel
        if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_e ? `LRCI_SLVERR : `LRCI_OKAY;
            if (s_axi_araddr == `LRCI_A_RXC) begin
                rxv_r <= 1'b0; // RULE20
            end
        end
        if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        // Loop transmit
        if (key_w & tonly_r & ~prn_r) begin
            prn_r <= 1'b1; // RULE19
            pidx_r <= 4'h0;
        end
        if (tx_free) begin
            if (spoll_r) begin
                lp_tx_valid <= 1'b1;
                lp_tx_kind <= `LRCI_K_DATA;
                lp_tx_byte <= stat_w; // RULE17
                spoll_r <= 1'b0;
                evt_r <= 8'h00; // RULE22
            end else if (ppreq_r) begin
                lp_tx_valid <= 1'b1;
                lp_tx_kind <= `LRCI_K_IDY;
                lp_tx_byte <= ppbyte_r; // RULE18
                ppreq_r <= 1'b0;
            end else if (prn_r) begin
                lp_tx_valid <= 1'b1;
                lp_tx_kind <= `LRCI_K_DATA;
                lp_tx_byte <= disp_r[pidx_r]; // RULE19
                pidx_r <= pidx_r + 4'h1;
                if (pidx_r == `LRCI_DLAST) begin
                    prn_r <= 1'b0;
                end
            end else if (talk_r & txp_r) begin
                lp_tx_valid <= 1'b1;
                lp_tx_kind <= `LRCI_K_DATA;
                lp_tx_byte <= txd_r; // RULE20
                txp_r <= 1'b0; // RULE1 RULE2
            end
        end
        // Loop receive
        if (rel_w) begin
            hold_r <= 1'b0; // RULE3
            acc_r <= 1'b0;
            lp_rx_ack <= 1'b1;
        end
        if (take_w) begin
            lp_rx_ack <= 1'b1;
            case (lp_rx_kind)
                `LRCI_K_DATA: begin
                    if (lstn_r) begin
                        rxb_r <= b; // RULE20
                        rxv_r <= 1'b1;
                        if ((b == `LRCI_CH_LF) & ~early_r) begin
                            hold_r <= 1'b1; // RULE3 RULE5
                            lp_rx_ack <= 1'b0;
                        end
                        case (ou_st_r)
                            P_IDLE: ou_st_r <= (b == `LRCI_CH_O) ? P_O : P_IDLE;
                            P_O: ou_st_r <= (b == `LRCI_CH_U) ? P_U :
                                            (b == `LRCI_CH_O) ? P_O : P_IDLE;
                            P_U: begin
                                if ((b & `LRCI_CH_DMASK) == `LRCI_CH_0) begin
                                    ou_dig_r <= b[`LRCI_DIGF];
                                    ou_st_r <= P_DIG;
                                end else begin
                                    ou_st_r <= P_IDLE;
                                end
                            end
                            P_DIG: begin
                                ou_st_r <= P_IDLE;
                                if (b == `LRCI_CH_SEMI) begin
                                    case (ou_dig_r)
                                        `LRCI_OU_MASK: srqen_r <= 1'b0; // RULE1 RULE23
                                        `LRCI_OU_REQ: srqen_r <= 1'b1; // RULE2 RULE23
                                        `LRCI_OU_HOLD: early_r <= 1'b0; // RULE3 RULE23
                                        default: early_r <= 1'b1; // RULE4 RULE23
                                    endcase
                                end
                            end
                            default: ou_st_r <= P_IDLE;
                        endcase
                    end
                end
                `LRCI_K_CMD: begin
                    ppc_r <= 1'b0;
                    if (b == `LRCI_C_IFC) begin
                        talk_r <= 1'b0; // RULE6
                        lstn_r <= 1'b0;
                    end else if (b == `LRCI_C_UNL) begin
                        lstn_r <= 1'b0;
                    end else if (b == `LRCI_C_PPU) begin
                        ppcfg_r <= 1'b0;
                    end else if (b == `LRCI_C_PPC) begin
                        ppc_r <= lstn_r;
                    end else if (ppc_r & (b == `LRCI_C_PPD)) begin
                        ppcfg_r <= 1'b0;
                    end else if (ppc_r & (b[`LRCI_PF] == `LRCI_H_PPE)) begin
                        ppcfg_r <= 1'b1; // RULE18
                        ppsense_r <= b[`LRCI_PP_SENSE];
                        ppbit_r <= b[`LRCI_PP_BIT];
                    end else if (b[`LRCI_HF] == `LRCI_H_LAD) begin
                        if (b[`LRCI_AF] == addr_r) begin
                            lstn_r <= 1'b1;
                        end
                    end else if (b[`LRCI_HF] == `LRCI_H_TAD) begin
                        talk_r <= (b[`LRCI_AF] == addr_r); // RULE15
                    end
                    // Trigger, power-down and other commands are ignored: RULE16
                end
                `LRCI_K_RDY: begin
                    if ((b == `LRCI_R_SST) & talk_r) begin
                        spoll_r <= 1'b1; // RULE17
                    end else if (b[`LRCI_HF] == `LRCI_H_AAD) begin
                        addr_r <= b[`LRCI_AF]; // RULE14
                    end
                end
                `LRCI_K_IDY: begin
                    if (ppcfg_r) begin
                        ppreq_r <= 1'b1; // RULE18
                        ppbyte_r <= b | ((need_w == ppsense_r) ? (8'h01 << ppbit_r) : 8'h00);
                    end
                end
                default: ;
            endcase
        end
        if (dclr_w) begin
            rxv_r <= 1'b0;
            hold_r <= 1'b0;
            acc_r <= 1'b0;
            txp_r <= 1'b0;
            evt_r <= 8'h00;
            spoll_r <= 1'b0;
            prn_r <= 1'b0;
            ou_st_r <= P_IDLE;
            for (i = 0; i < `LRCI_NSET; i = i + 1) begin
                set_r[i] <= f_def(i[2:0]); // RULE8 RULE9 RULE10 RULE11 RULE12 RULE13
            end
        end
        // Register write channel
        if (s_axi_awvalid & s_axi_awready) begin
            awv_r <= 1'b1;
            wa_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            wv_r <= 1'b1;
            wd_r <= s_axi_wdata;
            ws_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (wr_go) begin
            awv_r <= 1'b0;
            wv_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `LRCI_OKAY;
            if (wa_r == `LRCI_A_CTRL) begin
                if (ws_r[0]) tonly_r <= wd_r[`LRCI_F_TONLY];
            end else if (wa_r == `LRCI_A_STAT) begin
                if (ws_r[0]) evt_r <= wd_r[7:0]; // RULE22
            end else if (wa_r == `LRCI_A_TXD) begin
                if (ws_r[0]) begin
                    txd_r <= wd_r[7:0]; // RULE20
                    txp_r <= 1'b1;
                end
            end else if (wa_r == `LRCI_A_ACC) begin
                if (ws_r[0] & wd_r[0] & hold_r & ~rel_w) acc_r <= 1'b1; // RULE3
            end else if (f_inset(wa_r)) begin
                set_r[f_sidx(wa_r)] <= f_merge(set_r[f_sidx(wa_r)], wd_r, ws_r);
            end else if (f_indisp(wa_r)) begin
                if (ws_r[0]) disp_r[wa_r[`LRCI_DF]] <= wd_r[7:0];
            end else if (wa_r != `LRCI_A_RXC) begin
                s_axi_bresp <= `LRCI_SLVERR;
            end
        end
        if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end
endmodule

// ===== verification/lrci_top_sva.sv
// Port assertions for the loop remote command interface
`timescale 1ns/1ns
`include "lrci_defines.vh"
module lrci_chk (
    input wire mclk,
    input wire rstn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire lp_rx_valid,
    input wire lp_rx_ack,
    input wire lp_tx_valid,
    input wire [1:0] lp_tx_kind,
    input wire [7:0] lp_tx_byte,
    input wire lp_tx_ready,
    input wire lp_srq
);
    reg [7:0] rd_addr_r;
    wire stat_rd;
    assign stat_rd = s_axi_rvalid && (rd_addr_r == `LRCI_A_STAT);
    always @(posedge mclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_r <= s_axi_araddr;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // ----
    // Properties
    // ----
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer timing");
    property p_rd_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer timing");
    property p_stat_top;
        stat_rd |-> s_axi_rdata[7];
    endproperty
    a_stat_top: assert property (p_stat_top) else $error("status bit 7 low");
    property p_mask_srq;
        stat_rd && s_axi_rdata[7:0] == `LRCI_ST_RDY |-> !lp_srq;
    endproperty
    a_mask_srq: assert property (p_mask_srq) else $error("request in masked mode");
    property p_req_srq;
        stat_rd && s_axi_rdata[7:0] == `LRCI_ST_RDYSRQ |-> lp_srq;
    endproperty
    a_req_srq: assert property (p_req_srq) else $error("request missing");
    property p_no_ctrl;
        lp_tx_valid |-> lp_tx_kind != `LRCI_K_CMD && lp_tx_kind != `LRCI_K_RDY;
    endproperty
    a_no_ctrl: assert property (p_no_ctrl) else $error("controller frame sent");
    property p_ack;
        lp_rx_ack |-> lp_rx_valid ##1 !lp_rx_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bad receive ack");
    property p_tx_hold;
        lp_tx_valid && !lp_tx_ready
            |=> lp_tx_valid && $stable(lp_tx_byte) && $stable(lp_tx_kind);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("frame changed while held");
    c_stat: cover property (stat_rd);
    c_stall: cover property (lp_tx_valid && !lp_tx_ready);
    c_srq: cover property ($rose(lp_srq));
endmodule
bind lrci_top lrci_chk u_lrci_chk (.*);

// ===== verification/lrci_loop.sv
// Loop framer model: offers controller frames and collects outgoing frames
`timescale 1ns/1ns
module lrci_loop (
    input wire mclk,
    input wire stall,
    output reg lp_rx_valid,
    output reg [1:0] lp_rx_kind,
    output reg [7:0] lp_rx_byte,
    input wire lp_rx_ack,
    input wire lp_tx_valid,
    input wire [1:0] lp_tx_kind,
    input wire [7:0] lp_tx_byte,
    output reg lp_tx_ready
);
    reg [9:0] txq[$];
    initial begin
        lp_rx_valid = 1'b0;
        lp_rx_kind = 2'h0;
        lp_rx_byte = 8'h00;
        lp_tx_ready = 1'b1;
    end
    // Frame held until acknowledged, then the byte line shows junk
    task send(input [1:0] k, input [7:0] b);
        @(posedge mclk);
        lp_rx_valid <= 1'b1;
        lp_rx_kind <= k;
        lp_rx_byte <= b;
        do @(posedge mclk); while (lp_rx_ack !== 1'b1);
        lp_rx_valid <= 1'b0;
        lp_rx_byte <= ~b;
    endtask
    always @(posedge mclk) begin
        lp_tx_ready <= !stall;
        if (lp_tx_valid && lp_tx_ready) begin
            txq.push_back({lp_tx_kind, lp_tx_byte});
        end
    end
endmodule

// ===== verification/lrci_top_tb_top.sv
// Testbench for the loop remote command interface
`timescale 1ns/1ns
`include "lrci_defines.vh"
module lrci_top_tb_top;
    reg mclk, rstn, ce, stall, out_key_n, done;
    reg [7:0] s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata, d;
    reg [3:0] s_axi_wstrb;
    reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, lp_rx_kind, lp_tx_kind;
    wire [31:0] s_axi_rdata;
    wire lp_rx_valid, lp_rx_ack, lp_tx_valid, lp_tx_ready, lp_srq;
    wire [7:0] lp_rx_byte, lp_tx_byte;
    reg [31:0] dflt [0:6];
    integer miscompares, samples_checked, i, j;
    lrci_top u_lrci_top (.*);
    lrci_loop u_lrci_loop (.*);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // ----
    // Shared tasks
    // ----
    task chk(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_frame(input [9:0] exp);
        reg [9:0] got;
        got = 10'h3FF;
        if (u_lrci_loop.txq.size() > 0) begin
            got = u_lrci_loop.txq.pop_front();
        end
        chk({22'h0, got}, {22'h0, exp});
    endtask
    task wr(input [7:0] a, input [31:0] v, input [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task rd(input [7:0] a, input [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
        rd(a, `LRCI_OKAY);
        chk(d & m, e);
    endtask
    task cmd(input [1:0] k, input [7:0] b);
        u_lrci_loop.send(k, b);
    endtask
    // Four mnemonic characters, each popped by firmware, then line feed
    task mnem(input [31:0] s, input held);
        for (i = 3; i >= 0; i = i - 1) begin
            cmd(`LRCI_K_DATA, s[i*8 +: 8]);
            rdc(`LRCI_A_RXC, 32'h0000_01FF, {24'h1, s[i*8 +: 8]});
        end
        done = 1'b0;
        fork
            begin
                cmd(`LRCI_K_DATA, `LRCI_CH_LF);
                done = 1'b1;
            end
            begin
                repeat (6) @(posedge mclk);
                chk({31'h0, done}, {31'h0, !held});
                rdc(`LRCI_A_RXC, 32'h0000_01FF, 32'h0000_010A);
                if (held) wr(`LRCI_A_ACC, 32'h0000_0001, `LRCI_OKAY);
            end
        join
    endtask
    task report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #(100 * 20000);
        miscompares = miscompares + 1;
        report_and_stop;
    end
    // ----
    // Scenarios
    // ----
    initial begin
        miscompares = 0;
        samples_checked = 0;
        {rstn, stall, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h0;
        {ce, out_key_n, s_axi_bready, s_axi_rready} = 4'hF;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        dflt = '{`LRCI_D_FREQ, `LRCI_D_SWEEP, `LRCI_D_SWCTL, `LRCI_D_TRANS,
            `LRCI_D_TRANS2, `LRCI_D_MISC, `LRCI_D_CHK};
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rdc(`LRCI_A_STAT, 32'h000F_FFFF, 32'h0000_8080);
        wr(8'h30, 32'h0000_0001, `LRCI_SLVERR);
        rd(8'h80, `LRCI_SLVERR);
        cmd(`LRCI_K_CMD, 8'h21);
        for (j = 0; j < 2; j = j + 1) begin
            for (i = 0; i < 7; i = i + 1) wr(`LRCI_A_SET0 + 8'(4 * i), 32'h0, `LRCI_OKAY);
            cmd(`LRCI_K_CMD, j ? `LRCI_C_SDC : `LRCI_C_DCL);
            for (i = 0; i < 7; i = i + 1) begin
                rdc(`LRCI_A_SET0 + 8'(4 * i), 32'hFFFF_FFFF, dflt[i]);
            end
        end
        mnem(32'h4F55_313B, 1'b1);
        wr(`LRCI_A_TXD, 32'h0000_005A, `LRCI_OKAY);
        rdc(`LRCI_A_STAT, 32'h0000_01FF, 32'h0000_01E2);
        chk({31'h0, lp_srq}, 32'h1);
        cmd(`LRCI_K_CMD, 8'h41);
        repeat (8) @(posedge mclk);
        chk_frame({`LRCI_K_DATA, 8'h5A});
        rdc(`LRCI_A_STAT, 32'h0000_00FF, 32'h0000_0080);
        chk({31'h0, lp_srq}, 32'h0);
        cmd(`LRCI_K_CMD, 8'h5F);
        mnem(32'h4F55_303B, 1'b1);
        wr(`LRCI_A_TXD, 32'h0000_00A5, `LRCI_OKAY);
        rdc(`LRCI_A_STAT, 32'h0000_01FF, 32'h0000_00A2);
        chk({31'h0, lp_srq}, 32'h0);
        cmd(`LRCI_K_CMD, `LRCI_C_IFC);
        rdc(`LRCI_A_STAT, 32'h0000_0CFF, 32'h0000_00A2);
        wr(`LRCI_A_STAT, 32'h0000_00C7, `LRCI_OKAY);
        rdc(`LRCI_A_STAT, 32'h0000_00FF, 32'h0000_00C7);
        cmd(`LRCI_K_CMD, 8'h41);
        cmd(`LRCI_K_RDY, `LRCI_R_SST);
        repeat (8) @(posedge mclk);
        chk_frame({`LRCI_K_DATA, 8'hA5});
        chk_frame({`LRCI_K_DATA, 8'hC7});
        rdc(`LRCI_A_STAT, 32'h0000_00FF, 32'h0000_0080);
        cmd(`LRCI_K_CMD, 8'h21);
        cmd(`LRCI_K_CMD, `LRCI_C_PPC);
        cmd(`LRCI_K_CMD, 8'h8B);
        wr(`LRCI_A_STAT, 32'h0000_00C7, `LRCI_OKAY);
        cmd(`LRCI_K_IDY, 8'h00);
        repeat (8) @(posedge mclk);
        chk_frame({`LRCI_K_IDY, 8'h08});
        cmd(`LRCI_K_CMD, `LRCI_C_PPU);
        rdc(`LRCI_A_STAT, 32'h0000_4000, 32'h0000_0000);
        mnem(32'h4F55_333B, 1'b0);
        rdc(`LRCI_A_STAT, 32'h0000_2200, 32'h0000_0200);
        cmd(`LRCI_K_RDY, 8'h84);
        rdc(`LRCI_A_STAT, 32'h000F_8000, 32'h0002_0000);
        wr(`LRCI_A_CTRL, 32'h0000_0001, `LRCI_OKAY);
        for (i = 0; i < 16; i = i + 1) begin
            wr(`LRCI_A_DISP + 8'(4 * i), 32'h0000_0030 + 32'(i), `LRCI_OKAY);
        end
        stall <= 1'b1;
        out_key_n <= 1'b0;
        repeat (6) @(posedge mclk);
        out_key_n <= 1'b1;
        stall <= 1'b0;
        repeat (80) @(posedge mclk);
        for (i = 0; i < 16; i = i + 1) begin
            chk_frame({`LRCI_K_DATA, 8'(8'h30 + i)});
        end
        report_and_stop;
    end
endmodule
